// ===== common/mesc_pkg.sv
package mesc_pkg;

    // ------------------------------------------------------------
    // Counter slots, then the control and configuration register slots
    // ------------------------------------------------------------
    localparam int NUM_CNT = 12;
    localparam int IDX_LATE_COL = 0;
    localparam int IDX_EXCESS_COL = 1;
    localparam int IDX_TX_UNDERRUN = 2;
    localparam int IDX_CARRIER_ERR = 3;
    localparam int IDX_RX_NO_BUFFER = 4;
    localparam int IDX_RX_DMA_OVERRUN = 5;
    localparam int IDX_RX_SYMBOL_ERR = 6;
    localparam int IDX_OVERSIZE = 7;
    localparam int IDX_RX_JABBER = 8;
    localparam int IDX_UNDERSIZE = 9;
    localparam int IDX_HEARTBEAT_ERR = 10;
    localparam int IDX_LEN_MISMATCH = 11;
    localparam int IDX_CTRL = 12;
    localparam int IDX_CFG = 13;

    // Saturation values (all ones at each counter's width)
    localparam logic [15:0] CNT_MAX [NUM_CNT] = '{
        16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
        16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF
    };

    // ------------------------------------------------------------
    // Bus map: byte address is index times four
    // ------------------------------------------------------------
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // Control register fields
    localparam int CTRL_RX_EN_BIT = 2;
    localparam int CTRL_STAT_WR_BIT = 7;
    // Configuration register fields
    localparam int CFG_SPEED100_BIT = 0;
    localparam int CFG_FULL_DUPLEX_BIT = 1;
    localparam int CFG_BIG_FRAME_BIT = 8;
    localparam int CFG_LEN_CHECK_BIT = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0084;
    localparam logic [31:0] CFG_MASK = 32'h0001_0103;

    // ------------------------------------------------------------
    // Frame limits
    // ------------------------------------------------------------
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
    localparam logic [15:0] MAX_FRAME_LEN = 16'h05EE;
    localparam logic [15:0] MAX_BIG_FRAME_LEN = 16'h0600;
    localparam logic [15:0] TYPE_ID_MIN = 16'h0600;

    // ------------------------------------------------------------
    // Heartbeat window timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_100_NS = 10;
    localparam int BIT_TIME_10_NS = 100;
    localparam int HEARTBEAT_BITS = 96;
    localparam logic [10:0] HB_CYC_100 = 11'(HEARTBEAT_BITS * BIT_TIME_100_NS / CLK_PERIOD_NS);
    localparam logic [10:0] HB_CYC_10 = 11'(HEARTBEAT_BITS * BIT_TIME_10_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        MESC_HB_IDLE = 2'b01,
        MESC_HB_WAIT = 2'b10
    } mesc_hb_state_t;

endpackage

// ===== dv/mesc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

// PHY pins: collision and receive error on command
module mesc_phy_model (
    input wire logic clk_sys,
    input wire logic col_req,
    input wire logic err_req,
    output logic phy_col,
    output logic phy_rx_er
);
    initial begin
        phy_col = 1'h0;
        phy_rx_er = 1'h0;
    end

    // Collision a few cycles after the request, then pin released low
    always @(posedge clk_sys) begin
        if (col_req) begin
            repeat (6) @(posedge clk_sys);
            phy_col <= 1'h1;
            repeat (4) @(posedge clk_sys);
            phy_col <= 1'h0;
        end
    end

    // Receive error held three cycles inside a frame
    always @(posedge clk_sys) begin
        if (err_req) begin
            phy_rx_er <= 1'h1;
            repeat (3) @(posedge clk_sys);
            phy_rx_er <= 1'h0;
        end
    end
endmodule

`default_nettype wire

// ===== dv/mesc_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module mesc_top_test;
    logic clk_sys = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, collision_acct_pulse, fcs_align_err_pulse, phy_col, phy_rx_er;
    logic tx_frame_done = 1'h0, tx_underrun = 1'h0, tx_late_col = 1'h0, tx_excess_col = 1'h0;
    logic tx_collided = 1'h0, tx_crs_missing = 1'h0, mac_tx_en = 1'h0, col_req = 1'h0, err_req = 1'h0;
    logic rx_frame_done = 1'h0, rx_crc_err = 1'h0, rx_align_err = 1'h0, rx_addr_match = 1'h0;
    logic rx_no_buffer = 1'h0, rx_dma_overrun = 1'h0;
    logic [15:0] rx_frame_len = 16'h0, rx_len_field = 16'h0;
    int num_errors = 0, cmp_count = 0, cyc = 0;

    mesc_top mesc_top_inst (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_frame_done, .tx_underrun, .tx_late_col,
        .tx_excess_col, .tx_collided, .tx_crs_missing, .mac_tx_en, .phy_col, .phy_rx_er, .rx_frame_done,
        .rx_frame_len, .rx_len_field, .rx_crc_err, .rx_align_err, .rx_addr_match, .rx_no_buffer,
        .rx_dma_overrun, .collision_acct_pulse, .fcs_align_err_pulse);
    mesc_phy_model mesc_phy_model_inst (.clk_sys, .col_req, .err_req, .phy_col, .phy_rx_er);

    // Clock and cycle limit
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Bus and frame drivers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input int idx, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(idx * 4);
        @(posedge clk_sys);
        while (hreadyout !== 1'h1) @(posedge clk_sys);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'h1) @(posedge clk_sys);
        r = hrdata;
        chk(hresp, 1'h0);
    endtask
    task automatic wr(input int idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, idx, d, r);
    endtask
    task automatic rd(input int idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'h0, idx, 32'h0, r);
        chk(r, exp);
    endtask
    // Qualifiers: underrun, late, excess, collided, carrier missing
    task automatic txf(input logic [4:0] q);
        @(posedge clk_sys);
        tx_frame_done <= 1'h1;
        {tx_underrun, tx_late_col, tx_excess_col, tx_collided, tx_crs_missing} <= q;
        @(posedge clk_sys);
        tx_frame_done <= 1'h0;
        {tx_underrun, tx_late_col, tx_excess_col, tx_collided, tx_crs_missing} <= 5'h0;
    endtask
    // Qualifiers: crc, align, no buffer, dma overrun
    task automatic rxf(input logic [15:0] len, input logic [15:0] fld, input logic [3:0] q);
        @(posedge clk_sys);
        rx_frame_done <= 1'h1;
        rx_addr_match <= 1'h1;
        rx_frame_len <= len;
        rx_len_field <= fld;
        {rx_crc_err, rx_align_err, rx_no_buffer, rx_dma_overrun} <= q;
        @(posedge clk_sys);
        rx_frame_done <= 1'h0;
        rx_addr_match <= 1'h0;
        {rx_crc_err, rx_align_err, rx_no_buffer, rx_dma_overrun} <= 4'h0;
    endtask
    // Receive error burst ahead of the next frame
    task automatic rxerr();
        @(posedge clk_sys);
        err_req <= 1'h1;
        @(posedge clk_sys);
        err_req <= 1'h0;
        repeat (5) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_tx();
        rd(12, 32'h0);
        txf(5'h0A);
        #1 chk(collision_acct_pulse, 1'h1);
        txf(5'h1F);
        txf(5'h04);
        txf(5'h01);
        rd(0, 32'h1);
        rd(0, 32'h0);
        rd(1, 32'h1);
        rd(2, 32'h1);
        rd(3, 32'h1);
        wr(13, 32'h2);
        txf(5'h01);
        rd(3, 32'h0);
    endtask
    task automatic s_write();
        wr(0, 32'h5);
        rd(0, 32'h0);
        wr(12, 32'h84);
        wr(0, 32'hFFFF_FFFE);
        rd(0, 32'hFE);
        wr(0, 32'hFF);
        txf(5'h0A);
        wr(12, 32'h0);
        rd(0, 32'hFF);
    endtask
    task automatic s_rx();
        rxf(16'd40, 16'h0, 4'h0);
        rd(9, 32'h0);
        wr(12, 32'h4);
        rxerr();
        rxf(16'd100, 16'd200, 4'h0);
        #1 chk(fcs_align_err_pulse, 1'h1);
        rxerr();
        rxf(16'd2000, 16'h0, 4'h0);
        #1 chk(fcs_align_err_pulse, 1'h0);
        rxf(16'd2000, 16'h0, 4'h8);
        rxf(16'd2000, 16'h0, 4'h0);
        rxf(16'd63, 16'h0, 4'h0);
        rxf(16'd64, 16'h0, 4'h0);
        rxf(16'd70, 16'h0, 4'h2);
        rxf(16'd70, 16'h0, 4'h1);
        wr(9, 32'h5);
        rd(6, 32'h2);
        rd(8, 32'h2);
        rd(7, 32'h1);
        rd(9, 32'h1);
        rd(4, 32'h1);
        rd(5, 32'h1);
        wr(13, 32'h0001_0100);
        rxf(16'd1530, 16'h0, 4'h0);
        rxf(16'd100, 16'd200, 4'h0);
        rxf(16'd100, 16'h0700, 4'h0);
        rd(7, 32'h0);
        rd(11, 32'h1);
    endtask
    task automatic s_hb();
        wr(13, 32'h1);
        mac_tx_en <= 1'h1;
        repeat (5) @(posedge clk_sys);
        mac_tx_en <= 1'h0;
        repeat (130) @(posedge clk_sys);
        rd(10, 32'h1);
        mac_tx_en <= 1'h1;
        col_req <= 1'h1;
        @(posedge clk_sys);
        col_req <= 1'h0;
        repeat (4) @(posedge clk_sys);
        mac_tx_en <= 1'h0;
        repeat (130) @(posedge clk_sys);
        rd(10, 32'h0);
        wr(13, 32'h0);
        mac_tx_en <= 1'h1;
        repeat (5) @(posedge clk_sys);
        mac_tx_en <= 1'h0;
        repeat (1100) @(posedge clk_sys);
        rd(10, 32'h0);
        repeat (110) @(posedge clk_sys);
        rd(10, 32'h1);
    endtask

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        s_tx();
        s_write();
        s_rx();
        s_hb();
        conclude();
    end
endmodule

`default_nettype wire

// ===== verilog/mesc_top.sv
// Operation
// [RULE_01] 8-bit late collision counter, one per frame colliding after 512 bit times.
// [RULE_02] Late collision also pulses general collision accounting, counting it twice.
// [RULE_03] 8-bit counter of frames abandoned after 16 collisions.
// [RULE_04] 8-bit counter of frames lost to transmit DMA underrun.
// [RULE_05] Underrun frame changes no other statistics counter.
// [RULE_06] 8-bit counter of clean frames where carrier sense was absent or dropped.
// [RULE_07] Carrier sense error counts only in half duplex.
// [RULE_08] Carrier sense error affects nothing but its own counter.
// [RULE_09] 16-bit counter of matched frames dropped for lack of receive buffer.
// [RULE_10] 8-bit counter of recognised frames lost to receive DMA overrun.
// [RULE_11] 8-bit counter of frames with rx_er seen at any point.
// [RULE_12] Symbol error at length 64 to max also reports an FCS/alignment error.
// [RULE_13] Symbol error above max length is recorded as jabber.
// [RULE_14] 8-bit counter of error-free frames above 1518, or 1536 with big frames.
// [RULE_15] 8-bit jabber counter of over-length frames with CRC, alignment or symbol error.
// [RULE_16] 8-bit counter of error-free frames shorter than 64 bytes.
// [RULE_17] Half duplex: count frames without col within 96 bit times after tx_en.
// [RULE_18] 8-bit counter of frames shorter than their length field.
// [RULE_19] Length field checking only when configuration bit 16 is set.
// [RULE_20] Type values 0x0600 and up, and over-length frames, are no mismatch.
// [RULE_21] Counters clear on read and saturate at all ones.
// [RULE_22] Receive counters increment only while receive enable is set.
// [RULE_23] Counter writes act only while control bit 7 is set.
// [RULE_24] Counter sits in low bits; upper bits read zero, ignore writes.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mesc_top (
    input wire logic clk_sys,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Transmit engine events
    input wire logic tx_frame_done,
    input wire logic tx_underrun,
    input wire logic tx_late_col,
    input wire logic tx_excess_col,
    input wire logic tx_collided,
    input wire logic tx_crs_missing,
    input wire logic mac_tx_en,
    // PHY pins
    input wire logic phy_col,
    input wire logic phy_rx_er,
    // Receive engine events
    input wire logic rx_frame_done,
    input wire logic [15:0] rx_frame_len,
    input wire logic [15:0] rx_len_field,
    input wire logic rx_crc_err,
    input wire logic rx_align_err,
    input wire logic rx_addr_match,
    input wire logic rx_no_buffer,
    input wire logic rx_dma_overrun,
    // To the other statistics half
    output logic collision_acct_pulse,
    output logic fcs_align_err_pulse
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic col_meta;
    logic col_sync;
    logic rx_er_meta;
    logic rx_er_sync;

    // Two-stage capture of PHY pins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            col_meta <= 1'b0;
            col_sync <= 1'b0;
            rx_er_meta <= 1'b0;
            rx_er_sync <= 1'b0;
        end else begin
            col_meta <= phy_col;
            col_sync <= col_meta;
            rx_er_meta <= phy_rx_er;
            rx_er_sync <= rx_er_meta;
        end
    end

    // ------------------------------------------------------------
    // Control and configuration
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] cfg_reg;
    logic rx_en;
    logic stat_wr_en;
    logic speed_100;
    logic full_duplex;
    logic big_frames;
    logic len_check;

    assign rx_en = ctrl_reg[mesc_pkg::CTRL_RX_EN_BIT];
    assign stat_wr_en = ctrl_reg[mesc_pkg::CTRL_STAT_WR_BIT];
    assign speed_100 = cfg_reg[mesc_pkg::CFG_SPEED100_BIT];
    assign full_duplex = cfg_reg[mesc_pkg::CFG_FULL_DUPLEX_BIT];
    assign big_frames = cfg_reg[mesc_pkg::CFG_BIG_FRAME_BIT];
    assign len_check = cfg_reg[mesc_pkg::CFG_LEN_CHECK_BIT];

    // ------------------------------------------------------------
    // AHB-Lite address and data phase
    // ------------------------------------------------------------
    logic addr_valid;
    logic [5:0] addr_idx;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic rd_take;

    assign addr_valid = hsel && htrans[1] && hready;
    assign addr_idx = haddr[mesc_pkg::ADDR_MSB:mesc_pkg::ADDR_LSB];
    assign rd_take = addr_valid && !hwrite;

    // Latch a write address phase for the following data phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pend <= 1'b0;
            wr_idx <= '0;
        end else if (hready) begin
            wr_pend <= addr_valid && hwrite;
            wr_idx <= addr_idx;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Control registers written in the data phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= '0;
            cfg_reg <= '0;
        end else if (wr_pend) begin
            if (wr_idx == 6'(mesc_pkg::IDX_CTRL)) begin
                ctrl_reg <= hwdata & mesc_pkg::CTRL_MASK;
            end
            if (wr_idx == 6'(mesc_pkg::IDX_CFG)) begin
                cfg_reg <= hwdata & mesc_pkg::CFG_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit event decode
    // ------------------------------------------------------------
    logic tx_ok;
    logic inc_late;
    logic inc_excess;
    logic inc_underrun;
    logic inc_carrier;
    logic inc_heartbeat;

    assign tx_ok = tx_frame_done && !tx_underrun; // RULE_05
    assign inc_late = tx_ok && tx_late_col; // RULE_01
    assign inc_excess = tx_ok && tx_excess_col; // RULE_03
    assign inc_underrun = tx_frame_done && tx_underrun; // RULE_04
    // Independent of every other counter
    assign inc_carrier = tx_ok && !tx_collided && tx_crs_missing && !full_duplex; // RULE_06 RULE_07 RULE_08

    // Late collision also reported to collision accounting
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            collision_acct_pulse <= 1'b0;
        end else begin
            collision_acct_pulse <= inc_late; // RULE_02
        end
    end

    // ------------------------------------------------------------
    // Heartbeat window after tx_en falls
    // ------------------------------------------------------------
    mesc_pkg::mesc_hb_state_t hb_state;
    logic [10:0] hb_count;
    logic tx_en_d;
    logic hb_expire;
    logic underrun_seen;

    assign hb_expire = (hb_state == mesc_pkg::MESC_HB_WAIT) && (hb_count == 11'h001) && !col_sync;
    assign inc_heartbeat = hb_expire; // RULE_17

    // Tracks whether the current frame underran
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            underrun_seen <= 1'b0;
        end else if (inc_underrun) begin
            underrun_seen <= 1'b1;
        end else if (mac_tx_en && !tx_en_d) begin
            underrun_seen <= 1'b0;
        end
    end

    // Window timer: col inside window cancels the count
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hb_state <= mesc_pkg::MESC_HB_IDLE;
            hb_count <= '0;
            tx_en_d <= 1'b0;
        end else begin
            tx_en_d <= mac_tx_en;
            unique case (hb_state)
                mesc_pkg::MESC_HB_IDLE: begin
                    if (tx_en_d && !mac_tx_en && !full_duplex && !underrun_seen && !inc_underrun) begin
                        hb_state <= mesc_pkg::MESC_HB_WAIT; // RULE_17 RULE_05
                        hb_count <= speed_100 ? mesc_pkg::HB_CYC_100 : mesc_pkg::HB_CYC_10;
                    end
                end
                mesc_pkg::MESC_HB_WAIT: begin
                    if (col_sync || hb_count == 11'h001) begin
                        hb_state <= mesc_pkg::MESC_HB_IDLE;
                    end
                    hb_count <= hb_count - 11'h001;
                end
                default: begin
                    hb_state <= mesc_pkg::MESC_HB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive event decode
    // ------------------------------------------------------------
    logic rx_er_seen;
    logic rx_sym;
    logic [15:0] max_len;
    logic too_long;
    logic too_short;
    logic any_err;
    logic rx_done_en;
    logic inc_no_buffer;
    logic inc_overrun;
    logic inc_symbol;
    logic inc_oversize;
    logic inc_jabber;
    logic inc_undersize;
    logic inc_len_mismatch;

    // Sticky rx_er within a frame; a new error wins over the clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_er_seen <= 1'b0;
        end else if (rx_er_sync) begin
            rx_er_seen <= 1'b1;
        end else if (rx_frame_done) begin
            rx_er_seen <= 1'b0;
        end
    end

    assign rx_sym = rx_er_seen || rx_er_sync; // RULE_11
    assign max_len = big_frames ? mesc_pkg::MAX_BIG_FRAME_LEN : mesc_pkg::MAX_FRAME_LEN;
    assign too_long = rx_frame_len > max_len;
    assign too_short = rx_frame_len < mesc_pkg::MIN_FRAME_LEN;
    assign any_err = rx_crc_err || rx_align_err || rx_sym;
    assign rx_done_en = rx_frame_done && rx_en; // RULE_22
    assign inc_no_buffer = rx_done_en && rx_addr_match && rx_no_buffer; // RULE_09
    assign inc_overrun = rx_done_en && rx_addr_match && rx_dma_overrun; // RULE_10
    assign inc_symbol = rx_done_en && rx_sym; // RULE_11
    assign inc_oversize = rx_done_en && too_long && !any_err; // RULE_14
    assign inc_jabber = rx_done_en && too_long && any_err; // RULE_13 RULE_15
    assign inc_undersize = rx_done_en && too_short && !any_err; // RULE_16
    assign inc_len_mismatch = rx_done_en && len_check && !too_long // RULE_19
        && (rx_len_field < mesc_pkg::TYPE_ID_MIN) && (rx_frame_len < rx_len_field); // RULE_18 RULE_20

    // Symbol error at valid length reported as FCS or alignment error
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fcs_align_err_pulse <= 1'b0;
        end else begin
            fcs_align_err_pulse <= rx_done_en && rx_sym && !too_long && !too_short; // RULE_12
        end
    end

    // ------------------------------------------------------------
    // Counter bank
    // ------------------------------------------------------------
    logic [mesc_pkg::NUM_CNT-1:0] inc;
    logic [15:0] cnt [mesc_pkg::NUM_CNT];

    assign inc = {inc_len_mismatch, inc_heartbeat, inc_undersize, inc_jabber, inc_oversize, inc_symbol,
        inc_overrun, inc_no_buffer, inc_carrier, inc_underrun, inc_excess, inc_late};

    genvar gi;
    generate
        for (gi = 0; gi < mesc_pkg::NUM_CNT; gi++) begin : g_cnt
            logic wr_hit;
            logic rd_hit;
            logic [15:0] base;
            logic [15:0] next_cnt;

            assign wr_hit = wr_pend && stat_wr_en && (wr_idx == 6'(gi)); // RULE_23
            assign rd_hit = rd_take && (addr_idx == 6'(gi));

            // Write, then clear on read, then saturating increment
            always_comb begin
                base = wr_hit ? (hwdata[15:0] & mesc_pkg::CNT_MAX[gi]) : cnt[gi]; // RULE_24
                if (rd_hit) begin
                    base = mesc_pkg::CNT_RESET; // RULE_21
                end
                next_cnt = base;
                if (inc[gi] && base != mesc_pkg::CNT_MAX[gi]) begin
                    next_cnt = base + 16'h0001; // RULE_21
                end
            end

            // Counter storage
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    cnt[gi] <= mesc_pkg::CNT_RESET;
                end else begin
                    cnt[gi] <= next_cnt;
                end
            end

            chk_cnt_saturate: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_21
                (cnt[gi] == mesc_pkg::CNT_MAX[gi] && !rd_hit && !wr_hit) |=> cnt[gi] == mesc_pkg::CNT_MAX[gi])
                else $error("counter left saturation");
            chk_read_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_21
                (rd_hit && !inc[gi]) |=> cnt[gi] == 16'h0000)
                else $error("counter not cleared by read");
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data, captured in the address phase
    // ------------------------------------------------------------
    logic [31:0] next_rdata;

    // Forward a write in flight to the same slot
    always_comb begin
        next_rdata = '0;
        if (addr_idx < 6'(mesc_pkg::NUM_CNT)) begin
            if (wr_pend && stat_wr_en && wr_idx == addr_idx) begin
                next_rdata = {16'h0000, hwdata[15:0] & mesc_pkg::CNT_MAX[addr_idx[3:0]]}; // RULE_24
            end else begin
                next_rdata = {16'h0000, cnt[addr_idx[3:0]]}; // RULE_24
            end
        end else if (addr_idx == 6'(mesc_pkg::IDX_CTRL)) begin
            next_rdata = ctrl_reg;
        end else if (addr_idx == 6'(mesc_pkg::IDX_CFG)) begin
            next_rdata = cfg_reg;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hrdata <= '0;
        end else if (rd_take) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_tx_en_fall;
        tx_en_d && !mac_tx_en && !full_duplex && !underrun_seen && !inc_underrun
            && hb_state == mesc_pkg::MESC_HB_IDLE && speed_100;
    endsequence

    sequence s_quiet_window;
        (!col_sync && !mac_tx_en) [*8];
    endsequence

    chk_late_twice: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_02
        inc_late |=> collision_acct_pulse && cnt[mesc_pkg::IDX_LATE_COL] != 16'h0000)
        else $error("late collision not counted twice");
    chk_underrun_alone: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_05
        inc_underrun |-> !inc_late && !inc_excess && !inc_carrier && !inc_heartbeat)
        else $error("underrun frame touched another counter");
    chk_carrier_half: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_07
        full_duplex |-> !inc_carrier)
        else $error("carrier error counted in full duplex");
    chk_rx_gated: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_22
        !rx_en |-> {inc[mesc_pkg::IDX_LEN_MISMATCH],
            inc[mesc_pkg::IDX_UNDERSIZE:mesc_pkg::IDX_RX_NO_BUFFER]} == 7'h00)
        else $error("receive counter moved while disabled");
    chk_heartbeat_window: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_17
        s_tx_en_fall ##1 s_quiet_window |-> ##[1:112] (col_sync || inc_heartbeat))
        else $error("heartbeat error not counted in window");
    chk_heartbeat_col: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_17
        col_sync |-> !inc_heartbeat)
        else $error("heartbeat error counted despite col");
    chk_write_gated: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_23
        (wr_pend && !stat_wr_en && wr_idx == 6'(mesc_pkg::IDX_UNDERSIZE) && !inc_undersize && !rd_take)
            |=> $stable(cnt[mesc_pkg::IDX_UNDERSIZE]))
        else $error("counter written while writes disabled");
    chk_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_24
        $past(rd_take) && $past(addr_idx) < 6'(mesc_pkg::NUM_CNT) |-> hrdata[31:16] == 16'h0000)
        else $error("upper counter bits not zero");
    chk_jabber_split: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_15
        (rx_done_en && too_long) |-> (inc_jabber != inc_oversize) && !inc_len_mismatch)
        else $error("over-length frame misclassified");
    chk_symbol_fcs: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_12
        (inc_symbol && !too_long && !too_short) |=> fcs_align_err_pulse)
        else $error("symbol error not reported as FCS error");

endmodule

`default_nettype wire
